/* rtl/abw_pkg.sv */
// Shared constants for the system-bus to peripheral-bus bridge with write protection
package abw_pkg;

  // Bus widths and peripheral index field width
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;
  localparam int unsigned IDX_W  = 5;

  // Protection register offsets inside the bridge's own page
  localparam logic [7:0] PROT_CLR_OFS = 8'h00;
  localparam logic [7:0] PROT_SET_OFS = 8'h04;

  // Protection state reset value
  localparam logic [31:0] PROT_RESET = 32'h00000002;

  // Bridge's own register page: address bits [15:8]
  localparam logic [7:0] LOCAL_PAGE = 8'hFF;

  // Peripheral index field position in the address
  localparam int unsigned IDX_LSB = 10;

  // Transfer size encodings
  localparam logic [2:0] SIZE_BYTE = 3'h0;
  localparam logic [2:0] SIZE_HALF = 3'h1;
  localparam logic [2:0] SIZE_WORD = 3'h2;

  // Transfer type bit that marks a real request
  localparam int unsigned TRANS_ACTIVE_BIT = 1;

  // Bridge sequencer states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_WDATA  = 4'b0010,
    ST_ACCESS = 4'b0100,
    ST_ERR    = 4'b1000
  } abw_state_t;

endpackage

/* rtl/abw_lane_decode.sv */
// Byte-lane strobe decoder from transfer size and low address bits
`timescale 1ns/1ns
module abw_lane_decode
  import abw_pkg::*;
(
  // Transfer shape
  input  wire logic [2:0]        size_i,
  input  wire logic [1:0]        addr_lo_i,
  // Lane strobes
  output logic      [STRB_W-1:0] strb_o
);

  // One lane per byte, two for a half word, all four for a word
  always_comb begin
    unique case (size_i)
      SIZE_BYTE: strb_o = 4'h1 << addr_lo_i;
      SIZE_HALF: strb_o = addr_lo_i[1] ? 4'hC : 4'h3;
      default:   strb_o = 4'hF;
    endcase
  end

endmodule

/* rtl/abw_bridge.sv */
// System-bus slave to peripheral-bus bridge with per-peripheral write protection
// Notes on behaviour
// - The bridge is a system-bus slave and forwards each accepted transfer outside its own register page, except protected writes, to the peripheral bus.
// - The peripheral side uses APB4-style signals with no setup phase, with wait states, error return and protection attributes.
// - Byte, half-word and word writes drive only the matching byte-lane strobes.
// - Reads also carry lane strobes so a peripheral can see which lanes are targeted.
// - Address and data are presented in one peripheral cycle, select and enable rising together.
// - Writing 0 to a protection bit leaves that bit unchanged.
// - Writing 1 to a clear-register bit removes that protection, and reads show 1 while protected.
`timescale 1ns/1ns
module abw_bridge
  import abw_pkg::*;
(
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  // System bus slave
  input  wire logic              hsel_i,
  input  wire logic [ADDR_W-1:0] haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [3:0]        hprot_i,
  input  wire logic [DATA_W-1:0] hwdata_i,
  input  wire logic              hready_i,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  output logic      [DATA_W-1:0] hrdata_o,
  // Peripheral bus master
  output logic                   psel_o,
  output logic                   penable_o,
  output logic      [ADDR_W-1:0] paddr_o,
  output logic                   pwrite_o,
  output logic      [DATA_W-1:0] pwdata_o,
  output logic      [STRB_W-1:0] pstrb_o,
  output logic      [2:0]        pprot_o,
  input  wire logic [DATA_W-1:0] prdata_i,
  input  wire logic              pready_i,
  input  wire logic              pslverr_i,
  // Protection state, for peripherals that want to see it
  output logic      [31:0]       protect_o
);

  abw_state_t        state_reg;
  logic [31:0]       prot_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              write_reg;
  logic [2:0]        size_reg;
  logic [STRB_W-1:0] strb_reg;
  logic [STRB_W-1:0] strb_next;
  logic [31:0]       lane_mask;
  logic              accept;
  logic              local_hit;
  logic              blocked;
  logic              reg_wr;

  // A request is taken only in idle, so the data phase always sees a settled state
  assign accept    = (state_reg == ST_IDLE) && hsel_i && htrans_i[TRANS_ACTIVE_BIT] && hready_i;
  assign local_hit = (addr_reg[15:8] == LOCAL_PAGE);
  assign blocked   = write_reg && !local_hit && prot_reg[addr_reg[IDX_LSB +: IDX_W]];
  assign reg_wr    = (state_reg == ST_WDATA) && local_hit && write_reg;
  assign lane_mask = {{8{strb_reg[3]}}, {8{strb_reg[2]}}, {8{strb_reg[1]}}, {8{strb_reg[0]}}};

  // Lane strobes worked out in the address phase, for reads as well as writes
  abw_lane_decode u_lanes (
    .size_i    (hsize_i),
    .addr_lo_i (haddr_i[1:0]),
    .strb_o    (strb_next)
  );

  // Address-phase capture
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_reg  <= '0;
      write_reg <= 1'b0;
      size_reg  <= SIZE_WORD;
      strb_reg  <= '0;
    end else if (accept) begin
      addr_reg  <= haddr_i;
      write_reg <= hwrite_i;
      size_reg  <= hsize_i;
      strb_reg  <= strb_next;
    end
  end

  // Protection bits: set and clear registers, zero bits leave state alone
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prot_reg <= PROT_RESET;
    end else if (reg_wr && addr_reg[7:0] == PROT_CLR_OFS) begin
      prot_reg <= prot_reg & ~(hwdata_i & lane_mask);
    end else if (reg_wr && addr_reg[7:0] == PROT_SET_OFS) begin
      prot_reg <= prot_reg | (hwdata_i & lane_mask);
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      protect_o <= PROT_RESET;
    end else begin
      protect_o <= prot_reg;
    end
  end

  // Transfer sequencer; the peripheral cycle has no separate setup phase
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg   <= ST_IDLE;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      hrdata_o    <= '0;
      psel_o      <= 1'b0;
      penable_o   <= 1'b0;
      paddr_o     <= '0;
      pwrite_o    <= 1'b0;
      pwdata_o    <= '0;
      pstrb_o     <= '0;
      pprot_o     <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          hresp_o <= 1'b0; // Ends the second error cycle
          if (accept) begin
            hreadyout_o <= 1'b0;
            pprot_o     <= {~hprot_i[0], 1'b0, hprot_i[1]};
            state_reg   <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (local_hit) begin
            hrdata_o    <= prot_reg;
            hreadyout_o <= 1'b1;
            state_reg   <= ST_IDLE;
          end else if (blocked) begin
            hresp_o   <= 1'b1;
            state_reg <= ST_ERR;
          end else begin
            psel_o    <= 1'b1;
            penable_o <= 1'b1;
            paddr_o   <= addr_reg;
            pwrite_o  <= write_reg;
            pwdata_o  <= hwdata_i;
            pstrb_o   <= strb_reg;
            state_reg <= ST_ACCESS;
          end
        end
        ST_ACCESS: begin
          // Peripheral may stretch the cycle with wait states
          if (pready_i) begin
            psel_o    <= 1'b0;
            penable_o <= 1'b0;
            pstrb_o   <= '0;
            hrdata_o  <= prdata_i;
            if (pslverr_i) begin
              hresp_o   <= 1'b1;
              state_reg <= ST_ERR;
            end else begin
              hreadyout_o <= 1'b1;
              state_reg   <= ST_IDLE;
            end
          end
        end
        ST_ERR: begin
          // Two-cycle error: this edge opens the ready-high half
          hreadyout_o <= 1'b1;
          state_reg   <= ST_IDLE;
        end
      endcase
    end
  end

  // Checks beside the logic; the clock is assumed running while requests come

  AST_ZERO_WRITE_KEEPS: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    reg_wr && (hwdata_i == 32'h00000000) |=> $stable(prot_reg))
    else $error("protection changed on a write of zero");

  AST_CLEAR_REMOVES: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    reg_wr && addr_reg[7:0] == PROT_CLR_OFS && strb_reg == 4'hF
      |=> (prot_reg & $past(hwdata_i)) == 32'h00000000)
    else $error("clear write did not remove protection");

  AST_READ_SHOWS_STATE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_reg == ST_WDATA) && local_hit && !write_reg |=> hreadyout_o && hrdata_o == $past(prot_reg))
    else $error("protection read did not return state");

  AST_BLOCKED_ERROR: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_reg == ST_WDATA) && blocked
      |=> (hresp_o && !hreadyout_o && !psel_o) ##1 (hresp_o && hreadyout_o && !psel_o))
    else $error("protected write not refused with error");

  AST_FORWARD: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    accept && !hwrite_i && haddr_i[15:8] != LOCAL_PAGE |-> ##2 psel_o)
    else $error("accepted read not forwarded");

  AST_MERGED_CYCLE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $rose(psel_o) |-> penable_o && $past(state_reg) == ST_WDATA)
    else $error("select and enable not raised together");

  AST_WAIT_HOLDS: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    psel_o && !pready_i |=> psel_o && $stable(paddr_o) && $stable(pwdata_o) && !hreadyout_o)
    else $error("transfer not held during wait state");

  AST_SLVERR_RETURN: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    psel_o && pready_i && pslverr_i |=> hresp_o && !hreadyout_o ##1 hresp_o && hreadyout_o)
    else $error("peripheral error not returned");

  AST_BYTE_LANE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    psel_o && pwrite_o && size_reg == SIZE_BYTE |-> $countones(pstrb_o) == 1)
    else $error("byte write strobes wrong");

  AST_READ_LANES: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    psel_o && !pwrite_o |-> pstrb_o == strb_reg && pstrb_o != 4'h0)
    else $error("read carries no lane strobes");

endmodule

/* verification/abw_apb_model.sv */
// Peripheral register block model: wait states, error reply, idle bus pattern
`timescale 1ns/1ns
module abw_apb_model (
  // Clock and bus
  input  wire logic        clock_i,
  input  wire logic        psel_i,
  input  wire logic [31:0] paddr_i,
  // Test controls
  input  wire logic [1:0]  waits_i,
  input  wire logic        err_i,
  // Reply
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);
  logic [1:0] cnt_reg = 2'h0;
  logic       tog_reg = 1'b0;
  // Wait count restarts at each new select
  always_ff @(posedge clock_i) begin
    cnt_reg <= (psel_i && !pready_o) ? cnt_reg + 2'h1 : 2'h0;
    tog_reg <= ~tog_reg;
  end
  // Data only in the ready cycle; a stale value could hide a late sample
  assign pready_o  = psel_i && (cnt_reg == waits_i);
  assign prdata_o  = pready_o ? ~paddr_i : {16{tog_reg, ~tog_reg}};
  assign pslverr_o = pready_o && err_i;
endmodule

/* verification/abw_bridge_tb.sv */
// Testbench: bridge transfers, lane strobes and protection registers
`timescale 1ns/1ns
module abw_bridge_tb;
  import abw_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        hsel, hwrite, hresp, hrdy, psel, pen, pwr, prdy, perr, er, err_en, wr_seen, hrin;
  logic [1:0]  htrans, waits, lo;
  logic [2:0]  hsize, pprot, pp, sz;
  logic [3:0]  hprot, pstrb, ps, st;
  logic [31:0] haddr, hwdata, hrdata, paddr, pwdata, prdata, prot, rd, pw, pa;
  int          fail_count = 0;
  int          checks_done = 0;
  int          pcnt = 0;
  int          n;
  // Bridge clock runs before any transfer
  always #20 clock_i = ~clock_i;
  abw_bridge abw_bridge_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hprot_i(hprot), .hwdata_i(hwdata),
    .hready_i(hrin), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .psel_o(psel),
    .penable_o(pen), .paddr_o(paddr), .pwrite_o(pwr), .pwdata_o(pwdata), .pstrb_o(pstrb),
    .pprot_o(pprot), .prdata_i(prdata), .pready_i(prdy), .pslverr_i(perr), .protect_o(prot));
  abw_apb_model abw_apb_model_i (.clock_i(clock_i), .psel_i(psel), .paddr_i(paddr), .waits_i(waits),
    .err_i(err_en), .prdata_o(prdata), .pready_o(prdy), .pslverr_o(perr));
  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Peripheral side monitor, sampled mid-cycle so no edge race with the flops
  always @(negedge clock_i) if (psel === 1'b1) begin
    chk(pen, 1'b1);
    if (prdy === 1'b1) begin
      pcnt++;
      pa = paddr;
      ps = pstrb;
      pw = pwdata;
      pp = pprot;
      wr_seen = pwr;
    end
  end
  // One system-bus transfer; caller stands just after a rising edge
  task automatic x(input logic w, input logic [31:0] a, input logic [2:0] s, input logic [31:0] d);
    int k;
    hsel = 1'b1;
    htrans = 2'h2;
    hwrite = w;
    haddr = a;
    hsize = s;
    @(posedge clock_i);
    #1 hsel = 1'b0;
    htrans = 2'h0;
    hwdata = d;
    k = 0;
    // Ready and reply looked at mid-cycle, where they stand until the closing edge
    do begin
      @(negedge clock_i);
      k++;
    end while (hrdy !== 1'b1 && k < 20);
    rd = hrdata;
    er = hresp;
    if (hrdy !== 1'b1) begin
      fail_count++;
      summarize();
    end
    @(posedge clock_i);
    #1;
  endtask
  initial begin
    {hsel, hwrite, htrans, hsize, hprot, hwdata, haddr, waits, err_en} = '0;
    hrin = 1'b1;
    repeat (2) @(posedge clock_i);
    #1 rst_b_i = 1'b1;
    x(1'b0, 32'hFF00, SIZE_WORD, 32'h0);
    chk(rd, 32'h2);
    chk(prot, 32'h2);
    x(1'b0, 32'h400, SIZE_WORD, 32'h0);
    chk(rd, 32'hFFFFFBFF);
    chk(ps, 4'hF);
    chk(pa, 32'h400);
    chk(wr_seen, 1'b0);
    n = pcnt;
    x(1'b1, 32'h400, SIZE_WORD, 32'h5);
    chk(er, 1'b1);
    chk(pcnt, n);
    x(1'b1, 32'hFF00, SIZE_WORD, 32'h0);
    x(1'b1, 32'hFF04, SIZE_WORD, 32'h30);
    x(1'b1, 32'hFF00, SIZE_WORD, 32'h2);
    x(1'b0, 32'hFF04, SIZE_WORD, 32'h0);
    chk(rd, 32'h30);
    // Protection now off for index 1, so the same write goes through
    n = pcnt;
    x(1'b1, 32'h400, SIZE_WORD, 32'h5);
    chk(er, 1'b0);
    chk(pcnt, n + 1);
    x(1'b1, 32'hFF04, SIZE_BYTE, 32'hFFFFFF01);
    x(1'b0, 32'hFF00, SIZE_WORD, 32'h0);
    chk(rd, 32'h31);
    // Every size and lane offset, with a spread of protection attributes
    for (int i = 0; i < 7; i++) begin
      sz = i < 4 ? SIZE_BYTE : (i < 6 ? SIZE_HALF : SIZE_WORD);
      lo = 2'(i < 4 ? i : (i < 6 ? (i - 4) * 2 : 0));
      st = i < 4 ? 4'h1 << lo : (i < 6 ? (lo[1] ? 4'hC : 4'h3) : 4'hF);
      hprot = 4'(i);
      x(1'b1, 32'h800 | lo, sz, 32'hA5A50000 + i);
      chk(ps, st);
      chk(pw, 32'hA5A50000 + i);
      chk(pa, 32'h800 | lo);
      chk(wr_seen, 1'b1);
      chk(pp, {~hprot[0], 1'b0, hprot[1]});
    end
    x(1'b0, 32'h803, SIZE_BYTE, 32'h0);
    chk(ps, 4'h8);
    waits = 2'h2;
    x(1'b0, 32'hC00, SIZE_WORD, 32'h0);
    chk(rd, 32'hFFFFF3FF);
    err_en = 1'b1;
    x(1'b0, 32'hC00, SIZE_WORD, 32'h0);
    chk(er, 1'b1);
    err_en = 1'b0;
    x(1'b1, 32'hFF00, SIZE_WORD, 32'hFFFFFFFF);
    x(1'b0, 32'hFF04, SIZE_WORD, 32'h0);
    chk(rd, 32'h0);
    // Request while another slave stalls the bus must not be taken
    hrin = 1'b0;
    hsel = 1'b1;
    htrans = 2'h2;
    haddr = 32'h400;
    @(posedge clock_i);
    #1 hsel = 1'b0;
    htrans = 2'h0;
    hrin = 1'b1;
    chk(hrdy, 1'b1);
    chk(psel, 1'b0);
    rst_b_i = 1'b0;
    @(posedge clock_i);
    #1 rst_b_i = 1'b1;
    chk(prot, 32'h2);
    chk(hrdy, 1'b1);
    x(1'b0, 32'hFF00, SIZE_WORD, 32'h0);
    chk(rd, 32'h2);
    summarize();
  end
endmodule
